// File: pkg/flash_ctrl_pkg.sv
// constants for the flash self-programming controller
package flash_ctrl_pkg;
    // register map (word addresses on the plain port)
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] key_addr = 4'h1;
    localparam logic [3:0] page_addr = 4'h2;
    localparam logic [3:0] target_lo_addr = 4'h3;
    localparam logic [3:0] target_hi_addr = 4'h4;
    localparam logic [3:0] buf_lo_addr = 4'h5;
    localparam logic [3:0] buf_hi_addr = 4'h6;
    localparam logic [3:0] status_addr = 4'h7;
    // control field positions
    localparam int start_bit = 15;
    localparam int wen_bit = 14;
    localparam int err_bit = 13;
    localparam int erase_bit = 6;
    localparam int op_lsb = 0;
    localparam logic [15:0] ctrl_impl_mask = 16'he04f;
    localparam logic [15:0] ctrl_reset = 16'h0000;
    // unlock key values
    localparam logic [7:0] key_first = 8'h55;
    localparam logic [7:0] key_second = 8'haa;
    // operation codes
    localparam logic [3:0] op_bulk_erase = 4'hf;
    localparam logic [3:0] op_block_erase = 4'h2;
    localparam logic [3:0] op_row_program = 4'h1;
    // geometry
    localparam int row_words = 64;
    localparam int row_bytes = 192;
    localparam int block_bytes = 1536;
    // timing
    localparam int clock_mhz = 250;
    localparam int op_time_us = 4000;
    localparam int op_cycles = op_time_us * clock_mhz;
    typedef enum logic [1:0] {
        kind_none,
        kind_row_program,
        kind_block_erase,
        kind_bulk_erase
    } op_kind_e;
endpackage : flash_ctrl_pkg

// File: src/flash_self_program_controller.sv
// flash self-programming controller: unlock, control register, timed operation
// Notes on behaviour
// - no operation without correct unlock sequence
// - start bit 15 launches, hardware clears
// - software cannot clear start bit
// - operation lasts 4 ms, processor stalled
// - bit 14 write enable gates operations
// - bit 13 flags improper start attempts
// - bit 6 selects erase versus program
// - decode bulk, block erase, row program codes
// - other operation codes do nothing
// - unimplemented control bits read zero
// - control bits cleared only by power-on
// - 64-word holding buffer loaded sequentially
// - blocks and rows aligned to boundaries
// - target address from page and offset
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module flash_self_program_controller
    import flash_ctrl_pkg::*;
#(
    parameter int op_cycles_p = op_cycles
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic por_i,
    input wire logic enable_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [15:0] rdata_o,
    output logic stall_o,
    output logic flash_go_o,
    output logic [1:0] flash_kind_o,
    output logic [23:0] flash_addr_o
);
    // aligns a byte address down to a boundary
    function automatic logic [23:0] align_down(input logic [23:0] a, input int unsigned sz);
        align_down = a - 24'(32'(a) % sz);
    endfunction : align_down

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [7:0] page_reg;
    logic [15:0] offset_reg;
    logic [1:0] key_state_reg;
    logic [31:0] count_reg;
    logic busy_reg;
    logic [15:0] rdata_reg;
    logic go_reg;
    logic [1:0] kind_reg;
    logic [23:0] faddr_reg;
    logic [5:0] fill_reg;
    logic fill_ok_reg;
    logic [15:0] buf_lo_mem [row_words];
    logic [7:0] buf_hi_mem [row_words];

    // bus decode
    wire wr_ctrl = write_i && addr_i == ctrl_addr;
    wire wr_key = write_i && addr_i == key_addr;
    wire wr_page = write_i && addr_i == page_addr;
    wire wr_tgt = write_i && addr_i == target_lo_addr;
    wire wr_blo = write_i && addr_i == buf_lo_addr;
    wire wr_bhi = write_i && addr_i == buf_hi_addr;
    wire unlocked = key_state_reg == 2'd2;
    wire start_req = wr_ctrl && wdata_i[start_bit] && !busy_reg;

    // operation decode from the written control value
    wire [3:0] new_op = wdata_i[op_lsb +: 4];
    wire new_erase = wdata_i[erase_bit];
    wire [1:0] new_kind =
        (new_op == op_bulk_erase && new_erase) ? 2'(kind_bulk_erase) :
        (new_op == op_block_erase && new_erase) ? 2'(kind_block_erase) :
        (new_op == op_row_program && !new_erase) ? 2'(kind_row_program) :
        2'(kind_none);
    // launch needs unlock and write enable; a noop code launches nothing
    wire launch = start_req && unlocked && wdata_i[wen_bit]
        && new_kind != 2'(kind_none);
    wire bad_start = start_req && !launch;
    // 24-bit target address, aligned to the operation's granule
    wire [23:0] raw_addr = {page_reg, offset_reg};
    wire [23:0] op_addr = (new_kind == 2'(kind_block_erase)) ? align_down(raw_addr, block_bytes)
        : (new_kind == 2'(kind_row_program)) ? align_down(raw_addr, row_bytes)
        : 24'h000000;
    wire done = busy_reg && count_reg == 32'd1;

    // control next value: start only via launch, other implemented bits writable
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl && !busy_reg) begin
            ctrl_next = (wdata_i & ctrl_impl_mask) & ~(16'h1 << start_bit);
            // software may clear the flag, but a bad start in the same write wins
            ctrl_next[err_bit] = wdata_i[err_bit] | bad_start;
            ctrl_next[start_bit] = launch;
        end
        if (done) begin
            ctrl_next[start_bit] = 1'b0;
            ctrl_next[err_bit] = 1'b0;
        end
    end

    // control register survives ordinary reset, cleared by power-on only
    always_ff @(posedge clock_i) begin
        if (por_i) begin
            ctrl_reg <= ctrl_reset;
        end else if (enable_i) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // unlock tracker: any other write in between cancels the sequence
    always_ff @(posedge clock_i) begin
        if (reset_i || por_i) begin
            key_state_reg <= 2'd0;
        end else if (enable_i && write_i) begin
            if (wr_key && wdata_i[7:0] == key_first) begin
                key_state_reg <= 2'd1;
            end else if (wr_key && wdata_i[7:0] == key_second && key_state_reg == 2'd1) begin
                key_state_reg <= 2'd2;
            end else begin
                key_state_reg <= 2'd0;
            end
        end
    end

    // self-timed operation counter, stalls the processor while busy
    always_ff @(posedge clock_i) begin
        if (reset_i || por_i) begin
            busy_reg <= 1'b0;
            count_reg <= 32'd0;
            go_reg <= 1'b0;
            kind_reg <= 2'(kind_none);
            faddr_reg <= 24'h000000;
        end else if (enable_i) begin
            go_reg <= launch;
            if (launch) begin
                busy_reg <= 1'b1;
                count_reg <= 32'(op_cycles_p);
                kind_reg <= new_kind;
                faddr_reg <= op_addr;
            end else if (done) begin
                busy_reg <= 1'b0;
                count_reg <= 32'd0;
            end else if (busy_reg) begin
                count_reg <= count_reg - 32'd1;
            end
        end
    end

    // page and offset registers
    always_ff @(posedge clock_i) begin
        if (reset_i || por_i) begin
            page_reg <= 8'h00;
            offset_reg <= 16'h0000;
        end else if (enable_i) begin
            if (wr_page) begin
                page_reg <= wdata_i[7:0];
            end
            if (wr_tgt) begin
                offset_reg <= wdata_i;
            end
        end
    end

    // holding buffer: sequential fill, high half advances the slot
    always_ff @(posedge clock_i) begin
        if (reset_i || por_i) begin
            fill_reg <= 6'd0;
            fill_ok_reg <= 1'b0;
        end else if (enable_i) begin
            if (wr_bhi) begin
                fill_reg <= fill_reg + 6'd1;
                fill_ok_reg <= fill_reg == 6'd63;
            end else if (done) begin
                fill_ok_reg <= 1'b0;
            end
        end
    end

    // buffer storage, no reset needed
    always_ff @(posedge clock_i) begin
        if (enable_i && wr_blo) begin
            buf_lo_mem[fill_reg] <= wdata_i;
        end
        if (enable_i && wr_bhi) begin
            buf_hi_mem[fill_reg] <= wdata_i[7:0];
        end
    end

    // read mux; key register is write-only and reads zero
    wire [15:0] status_word = {10'h000, fill_ok_reg, busy_reg, unlocked, kind_reg, 1'b0};
    wire [15:0] read_word =
        (addr_i == ctrl_addr) ? ctrl_reg :
        (addr_i == page_addr) ? {8'h00, page_reg} :
        (addr_i == target_lo_addr) ? offset_reg :
        (addr_i == buf_lo_addr) ? buf_lo_mem[fill_reg] :
        (addr_i == buf_hi_addr) ? {8'h00, buf_hi_mem[fill_reg]} :
        (addr_i == status_addr) ? status_word :
        (addr_i == target_hi_addr) ? {8'h00, faddr_reg[23:16]} : 16'h0000;

    always_ff @(posedge clock_i) begin
        if (reset_i || por_i) begin
            rdata_reg <= 16'h0000;
        end else if (enable_i) begin
            rdata_reg <= read_i ? read_word : 16'h0000;
        end
    end

    assign rdata_o = rdata_reg;
    assign stall_o = busy_reg;
    assign flash_go_o = go_reg;
    assign flash_kind_o = kind_reg;
    assign flash_addr_o = faddr_reg;

    // assertions
    // keys with an idle bus cycle between them, as firmware usually issues them
    sequence unlock_seq;
        wr_key && wdata_i[7:0] == key_first ##1 !write_i ##1 wr_key && wdata_i[7:0] == key_second;
    endsequence
    // a start write that passes every gate
    sequence launch_seq;
        enable_i && launch;
    endsequence

    launch_needs_key_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && launch) |-> unlocked)
        else $error("launch without unlock");
    start_tracks_busy_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && launch) |=> (ctrl_reg[start_bit] && stall_o))
        else $error("start bit not set on launch");
    start_no_clear_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && busy_reg && !done) |=> ctrl_reg[start_bit])
        else $error("start bit cleared early");
    op_duration_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && done) |=> !stall_o && !ctrl_reg[start_bit])
        else $error("operation end mismatch");
    wen_gate_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && start_req && !wdata_i[wen_bit]) |=> !stall_o)
        else $error("start without write enable");
    err_flag_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && bad_start) |=> ctrl_reg[err_bit])
        else $error("error flag not set");
    unimpl_zero_a: assert property (@(posedge clock_i) disable iff (por_i)
        (ctrl_reg & ~ctrl_impl_mask) == 16'h0000)
        else $error("unimplemented bits set");
    noop_code_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && start_req && new_kind == 2'(kind_none)) |=> !flash_go_o)
        else $error("noop code launched");
    key_cancel_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && key_state_reg == 2'd1 && write_i && !wr_key) |=> !unlocked)
        else $error("unlock survived other write");
    unlock_ok_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i || !enable_i)
        unlock_seq |=> unlocked)
        else $error("unlock not reached");

    // launch strobe is a single-cycle pulse towards the flash array
    go_pulse_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        flash_go_o |=> !flash_go_o)
        else $error("go pulse too long");
    // normal completion leaves the error flag clear
    err_clear_done_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && done) |=> !ctrl_reg[err_bit])
        else $error("error flag left after completion");
    // erase select never yields a row program
    erase_kind_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (launch_seq and new_erase) |=> flash_kind_o != 2'(kind_row_program))
        else $error("erase select gave program");
    // a launched program select always yields a row program
    row_kind_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (launch_seq and !new_erase) |=> flash_kind_o == 2'(kind_row_program))
        else $error("program select gave erase");
    // control writes while busy leave the register alone
    busy_hold_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && busy_reg && !done && wr_ctrl) |=> ctrl_reg == $past(ctrl_reg))
        else $error("control changed while busy");
    // block erase address sits on an erase-block boundary
    block_align_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (flash_go_o && flash_kind_o == 2'(kind_block_erase))
            |-> (32'(flash_addr_o) % block_bytes) == 0)
        else $error("block address unaligned");
    // row program address sits on a row boundary
    row_align_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (flash_go_o && flash_kind_o == 2'(kind_row_program))
            |-> (32'(flash_addr_o) % row_bytes) == 0)
        else $error("row address unaligned");
    // the operation counter never exceeds the programmed operation length while busy
    stall_end_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        busy_reg |-> count_reg <= 32'(op_cycles_p))
        else $error("operation counter out of range");
    // the last half-word of a row marks the buffer full
    fill_full_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && wr_bhi && fill_reg == 6'd63) |=> fill_ok_reg)
        else $error("buffer full not flagged");
    // read data stands only in the cycle after a read strobe
    rdata_idle_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && !read_i) |=> rdata_o == 16'h0000)
        else $error("read data without read");
    // the key register is write-only and never echoes a key
    key_hidden_a: assert property (@(posedge clock_i) disable iff (reset_i || por_i)
        (enable_i && read_i && addr_i == key_addr) |=> rdata_o == 16'h0000)
        else $error("key register readable");
endmodule : flash_self_program_controller

// File: test/flash_self_program_controller_tb.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/100ps
module flash_self_program_controller_tb
    import flash_ctrl_pkg::*;
;
    localparam int op_len = 20;
    logic clock_i = 1'b0, reset_i = 1'b1, por_i = 1'b1, enable_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rd_val;
    logic write_i = 1'b0, read_i = 1'b0;
    logic [15:0] rdata_o;
    logic stall_o, flash_go_o;
    logic [1:0] flash_kind_o;
    logic [23:0] flash_addr_o;
    int n_mismatch = 0, tests_run = 0, stall_cnt = 0;
    // short op count keeps each operation to 20 cycles
    flash_self_program_controller #(.op_cycles_p(op_len)) dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .por_i(por_i), .enable_i(enable_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .stall_o(stall_o), .flash_go_o(flash_go_o),
        .flash_kind_o(flash_kind_o), .flash_addr_o(flash_addr_o));
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    // counts edges seen with the stall high
    always @(posedge clock_i) begin
        if (stall_o === 1'b1) stall_cnt <= stall_cnt + 1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // strobes last one edge; a lowered strobe is never re-raised in the same step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // mid inserts an unrelated write between the keys, bad spoils the first key
    task automatic unlock(input logic mid, input logic bad);
        wr(key_addr, bad ? 16'h0056 : {8'h00, key_first});
        if (mid) wr(page_addr, 16'h0000);
        wr(key_addr, {8'h00, key_second});
    endtask : unlock
    // configure, unlock, start, then judge launch, duration and final register
    task automatic run_op(input logic [15:0] cfg, input logic ok, input logic [1:0] kind,
                          input logic mid, input logic bad);
        int i;
        wr(ctrl_addr, cfg);
        unlock(mid, bad);
        stall_cnt = 0;
        wr(ctrl_addr, cfg | 16'h8000); // start right after keys
        #1;
        check({15'h0000, stall_o}, {15'h0000, ok});
        check({15'h0000, flash_go_o}, {15'h0000, ok});
        if (ok) begin
            check({14'h0000, flash_kind_o}, {14'h0000, kind});
            wr(ctrl_addr, cfg); // a zero written to start while busy must not stop it
            rd(ctrl_addr, rd_val);
            check(rd_val, (cfg & 16'h404f) | 16'h8000);
            for (i = 0; i < 200 && stall_o !== 1'b0; i++) @(posedge clock_i);
            #1;
            if (stall_o !== 1'b0) begin
                n_mismatch++;
                $display("[FAIL] %0t operation never finished", $time);
                end_of_test();
            end
            check(16'(stall_cnt), 16'(op_len));
            rd(ctrl_addr, rd_val);
            check(rd_val, cfg & 16'h404f);
        end else begin
            rd(ctrl_addr, rd_val);
            check(rd_val, (cfg & 16'h604f) | 16'h2000);
        end
    endtask : run_op
    task automatic fill_buffer();
        int i;
        for (i = 0; i < row_words; i++) begin
            wr(buf_lo_addr, 16'(i));
            wr(buf_hi_addr, 16'(i) & 16'h00ff);
        end
    endtask : fill_buffer
    task automatic t_power_defaults();
        rd(ctrl_addr, rd_val);
        check(rd_val, 16'h0000);
        wr(ctrl_addr, 16'hffff);
        #1 check({15'h0000, stall_o}, 16'h0000);
        rd(ctrl_addr, rd_val);
        check(rd_val, 16'h604f);
        $display("test done: power defaults");
    endtask : t_power_defaults
    task automatic t_op_codes();
        fill_buffer();
        run_op(16'h4001, 1'b1, 2'd1, 1'b0, 1'b0);
        run_op(16'h4042, 1'b1, 2'd2, 1'b0, 1'b0);
        run_op(16'h404f, 1'b1, 2'd3, 1'b0, 1'b0);
        run_op(16'h4041, 1'b0, 2'd0, 1'b0, 1'b0);
        run_op(16'h4002, 1'b0, 2'd0, 1'b0, 1'b0);
        run_op(16'h400f, 1'b0, 2'd0, 1'b0, 1'b0);
        run_op(16'h4043, 1'b0, 2'd0, 1'b0, 1'b0);
        run_op(16'h4040, 1'b0, 2'd0, 1'b0, 1'b0);
        $display("test done: operation codes");
    endtask : t_op_codes
    task automatic t_gating();
        run_op(16'h0042, 1'b0, 2'd0, 1'b0, 1'b0);
        run_op(16'h4042, 1'b0, 2'd0, 1'b1, 1'b0);
        run_op(16'h4042, 1'b0, 2'd0, 1'b0, 1'b1);
        run_op(16'h4042, 1'b1, 2'd2, 1'b0, 1'b0);
        $display("test done: gating");
    endtask : t_gating
    // erase a block, then program one of its rows, checking both aligned addresses
    task automatic t_address();
        wr(page_addr, 16'h0001);
        wr(target_lo_addr, 16'h0700);
        rd(page_addr, rd_val);
        check(rd_val, 16'h0001);
        run_op(16'h4042, 1'b1, 2'd2, 1'b0, 1'b0);
        check(flash_addr_o[15:0], 16'h0200);
        rd(target_hi_addr, rd_val);
        check(rd_val, 16'h0001);
        fill_buffer();
        rd(status_addr, rd_val);
        check(rd_val & 16'h0020, 16'h0020);
        run_op(16'h4001, 1'b1, 2'd1, 1'b0, 1'b0);
        check(flash_addr_o[15:0], 16'h0680);
        $display("test done: addresses");
    endtask : t_address
    task automatic t_resets();
        wr(ctrl_addr, 16'h4042);
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(ctrl_addr, rd_val);
        check(rd_val, 16'h4042);
        @(posedge clock_i);
        por_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        por_i <= 1'b0;
        rd(ctrl_addr, rd_val);
        check(rd_val, 16'h0000);
        $display("test done: resets");
    endtask : t_resets
    initial begin
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        por_i <= 1'b0;
        t_power_defaults();
        t_op_codes();
        t_gating();
        t_address();
        t_resets();
        end_of_test();
    end
    // hang guard
    initial begin
        repeat (50000) @(posedge clock_i);
        n_mismatch++;
        $display("[FAIL] %0t run timed out", $time);
        end_of_test();
    end
endmodule : flash_self_program_controller_tb
